// file: mmbd_pkg.sv
// Shared constants, types and helpers of the memory map bank decoder
package mmbd_pkg;

	// ----------------------------------------------------------------
	// Address map
	// ----------------------------------------------------------------
	localparam logic [15:0] IO_FIRST        = 16'h0000; // Peripheral area start
	localparam logic [15:0] IO_LAST         = 16'h007f; // Peripheral area end
	localparam logic [15:0] XIO_FIRST       = 16'h0f80; // Extended peripheral start
	localparam logic [15:0] XIO_LAST        = 16'h0fff; // Extended peripheral end
	localparam logic [15:0] DIRECT_RAM_LOW  = 16'h0090; // Unbanked direct RAM start
	localparam logic [15:0] DIRECT_RAM_HIGH = 16'h00ff; // Unbanked direct RAM end
	localparam logic [15:0] BANK_BASE       = 16'h0080; // Window offset added to banks
	localparam logic [15:0] GPR_FIRST       = 16'h0100; // Register area start
	localparam logic [15:0] GPR_LAST        = 16'h01ff; // Register area end
	localparam logic [15:0] NVSTORE_FIRST   = 16'hffbb; // Setting store start
	localparam logic [15:0] NVSTORE_LAST    = 16'hffbf; // Setting store end
	localparam logic [15:0] VEC_FIRST       = 16'hffc0; // Vector table start
	localparam logic [15:0] RAM_START_DEF   = 16'h0080; // Default RAM start
	localparam logic [15:0] RAM_END_DEF     = 16'h047f; // Default RAM end, large variant
	localparam logic [15:0] FLASH_START_DEF = 16'h8000; // Default flash start
	localparam int          IO_SIZE         = 128;      // Peripheral bytes
	localparam int          BANK_W          = 3;        // Bank pointer width
	localparam int          BANK_WIN_LSB    = 7;        // Window size is two to this
	localparam logic [2:0]  BANK_RESET      = 3'h0;     // Bank pointer after reset

	// ----------------------------------------------------------------
	// Reset values: the common zero and those of registers that do not clear to zero
	// ----------------------------------------------------------------
	localparam logic [7:0] RST_ZERO      = 8'h00; // Common reset value
	localparam logic [7:0] RST_OSC_WAIT  = 8'hff; // Settle wait time
	localparam logic [7:0] RST_SYSCLK    = 8'h1b; // Clock control, unknowns as 0
	localparam logic [7:0] RST_SYSCLK_2  = 8'h03; // Second clock control

	// ----------------------------------------------------------------
	// Types
	// ----------------------------------------------------------------
	// Kind of access the core issues
	typedef enum logic [1:0] {
		MODE_PLAIN       = 2'h0,
		MODE_DIRECT      = 2'h1,
		MODE_GPR         = 2'h2,
		MODE_VECTOR_CALL = 2'h3
	} mmbd_mode_t;

	// Decoded target, one-hot
	typedef enum logic [4:0] {
		RG_NONE  = 5'h01,
		RG_IO    = 5'h02,
		RG_XIO   = 5'h04,
		RG_RAM   = 5'h08,
		RG_FLASH = 5'h10
	} mmbd_region_t;

	// Peripheral register offsets
	typedef enum logic [6:0] {
		PORT0_OUTPUT_DATA = 7'h00, PORT0_DIRECTION = 7'h01,
		PORT1_OUTPUT_DATA = 7'h02, PORT1_DIRECTION = 7'h03,
		OSC_SETTLE_WAIT_TIME = 7'h05, PLL_CONTROL = 7'h06,
		SYSTEM_CLOCK_CONTROL = 7'h07, STANDBY_CONTROL = 7'h08,
		RESET_CAUSE = 7'h09, TIMEBASE_TIMER_CONTROL = 7'h0a,
		WATCH_PRESCALER_CONTROL = 7'h0b, WATCHDOG_CONTROL = 7'h0c,
		SYSTEM_CLOCK_CONTROL_SECOND = 7'h0d, STANDBY_CONTROL_SECOND = 7'h0e,
		PORT4_OUTPUT_DATA = 7'h11, PORT4_DIRECTION = 7'h12,
		PORT6_OUTPUT_DATA = 7'h16, PORT6_DIRECTION = 7'h17,
		PORT7_OUTPUT_DATA = 7'h18, PORT7_DIRECTION = 7'h19,
		PORTF_OUTPUT_DATA = 7'h28, PORTF_DIRECTION = 7'h29,
		PORTG_OUTPUT_DATA = 7'h2a, PORTG_DIRECTION = 7'h2b,
		PORT0_PULLUP_ENABLE = 7'h2c, PORT1_PULLUP_ENABLE = 7'h2d
	} mmbd_ioreg_t;

	// ----------------------------------------------------------------
	// Helpers
	// ----------------------------------------------------------------
	// Implemented flag and reset value of a peripheral offset
	function automatic logic [8:0] ioInfo(input logic [6:0] ofs);
		case (mmbd_ioreg_t'(ofs))
			OSC_SETTLE_WAIT_TIME:         ioInfo = {1'b1, RST_OSC_WAIT};
			SYSTEM_CLOCK_CONTROL:         ioInfo = {1'b1, RST_SYSCLK};
			SYSTEM_CLOCK_CONTROL_SECOND:  ioInfo = {1'b1, RST_SYSCLK_2};
			PORT0_OUTPUT_DATA, PORT0_DIRECTION, PORT1_OUTPUT_DATA, PORT1_DIRECTION,
			PLL_CONTROL, STANDBY_CONTROL, RESET_CAUSE, TIMEBASE_TIMER_CONTROL,
			WATCH_PRESCALER_CONTROL, WATCHDOG_CONTROL, STANDBY_CONTROL_SECOND,
			PORT4_OUTPUT_DATA, PORT4_DIRECTION, PORT6_OUTPUT_DATA, PORT6_DIRECTION,
			PORT7_OUTPUT_DATA, PORT7_DIRECTION, PORTF_OUTPUT_DATA, PORTF_DIRECTION,
			PORTG_OUTPUT_DATA, PORTG_DIRECTION, PORT0_PULLUP_ENABLE,
			PORT1_PULLUP_ENABLE:          ioInfo = {1'b1, RST_ZERO};
			default:                      ioInfo = {1'b0, RST_ZERO};
		endcase
	endfunction

	// Direct operand to physical address through the bank pointer
	function automatic logic [15:0] directMap(input logic [7:0] op, input logic [2:0] bank);
		if (!op[7] || bank == BANK_RESET)
			directMap = {8'h00, op};
		else
			directMap = {6'h00, bank, op[6:0]} + BANK_BASE;
	endfunction

endpackage

// file: mmbd_mem.sv
// Byte-wide memory with one write port and one registered read port
`timescale 1ns/1ps
module mmbd_mem #(
	parameter int AW    = 10,
	parameter int DEPTH = 1024
) (
	input  wire logic          clk,
	input  wire logic          rst,
	input  wire logic          wrEn,
	input  wire logic [AW-1:0] wrAddr,
	input  wire logic [7:0]    wrData,
	input  wire logic [AW-1:0] rdAddr,
	output logic      [7:0]    rdData
);
	// ----------------------------------------------------------------
	// Storage and read register
	// ----------------------------------------------------------------
	typedef struct packed {
		logic [7:0] rd; // Read data register
	} mmbd_mem_state_t;

	logic [7:0]      mem [DEPTH]; // Byte array
	mmbd_mem_state_t q;           // Registered state
	mmbd_mem_state_t d;           // Next state

	// Next read value
	always_comb
	begin
		d    = q;
		d.rd = mem[rdAddr];
	end

	// Read register
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
			q <= '0;
		else
			q <= d;
	end

	// Array write, no reset on storage
	always_ff @(posedge clk)
	begin
		if (wrEn)
			mem[wrAddr] <= wrData;
	end

	assign rdData = q.rd;
endmodule

// file: mmbd_translate.sv
// Combinational address translation and region decode
`timescale 1ns/1ps
module mmbd_translate
	import mmbd_pkg::*;
#(
	parameter logic [15:0] RAM_START   = 16'h0080,
	parameter logic [15:0] RAM_END     = 16'h047f,
	parameter logic [15:0] FLASH_START = 16'h8000
) (
	input  wire mmbd_pkg::mmbd_mode_t   accMode,
	input  wire logic [15:0]            accAddr,
	input  wire logic [2:0]             directBankPointer,
	output logic      [15:0]            physAddr,
	output mmbd_pkg::mmbd_region_t      region,
	output logic                        vectorHit,
	output logic                        nonvolatileSettingStore,
	output logic                        gprHit
);
	// ----------------------------------------------------------------
	// Translation and decode
	// ----------------------------------------------------------------
	always_comb
	begin
		// Physical address by access kind
		case (accMode)
			MODE_DIRECT:      physAddr = directMap(accAddr[7:0], directBankPointer); // [RQ11] [RQ12] [RQ13]
			MODE_GPR:         physAddr = GPR_FIRST + {8'h00, accAddr[7:0]}; // [RQ7]
			MODE_VECTOR_CALL: physAddr = VEC_FIRST + {10'h000, accAddr[5:0]}; // [RQ8]
			default:          physAddr = accAddr;
		endcase
		// Region of the physical address
		if (physAddr <= IO_LAST)
			region = RG_IO; // [RQ2]
		else if (accMode == MODE_PLAIN && physAddr >= XIO_FIRST && physAddr <= XIO_LAST)
			region = RG_XIO; // [RQ3]
		else if (physAddr >= RAM_START && physAddr <= RAM_END)
			region = RG_RAM; // [RQ4] [RQ5] [RQ6]
		else if (physAddr >= FLASH_START)
			region = RG_FLASH; // [RQ15]
		else
			region = RG_NONE; // [RQ15]
		// Special areas
		vectorHit = (region == RG_FLASH) && (physAddr >= VEC_FIRST); // [RQ8]
		nonvolatileSettingStore = (region == RG_FLASH) && (physAddr >= NVSTORE_FIRST)
			&& (physAddr <= NVSTORE_LAST); // [RQ10]
		gprHit = (region == RG_RAM) && (physAddr >= GPR_FIRST) && (physAddr <= GPR_LAST); // [RQ7]
	end
endmodule

// file: memory_map_bank_decoder.sv
// Top of the memory map bank decoder: register file, RAM, flash, banking
`timescale 1ns/1ps

// How it works
// RQ1: One 64 Kbyte space, four kinds of region
// RQ2: Low 128 bytes hold peripheral registers
// RQ3: Extended peripherals reached by plain access only
// RQ4: Direct 0x90-0xFF reaches RAM unbanked; the code banks it like 0x80-0x8F when the pointer is nonzero
// RQ5: Banked direct reach extends to 0x47F
// RQ6: Small variant banked reach stops at 0x28F
// RQ7: RAM 0x100-0x1FF doubles as registers
// RQ8: Top 64 flash bytes form vector table
// RQ9: Software stores routine addresses as vectors
// RQ10: Flash 0xFFBB-0xFFBF holds setting store data
// RQ11: Direct operands below 0x80 ignore bank
// RQ12: Bank pointer resets to zero, identity map
// RQ13: Nonzero bank selects successive 128-byte windows
// RQ14: Unmapped reads harmless, writes change nothing
// RQ15: Flash tops the space, gap decodes nothing
module memory_map_bank_decoder
	import mmbd_pkg::*;
#(
	parameter logic [15:0] RAM_START   = mmbd_pkg::RAM_START_DEF,
	parameter logic [15:0] RAM_END     = mmbd_pkg::RAM_END_DEF,
	parameter logic [15:0] FLASH_START = mmbd_pkg::FLASH_START_DEF
) (
	input  wire logic                   clk,
	input  wire logic                   rst,
	input  wire logic                   accReq,
	input  wire logic                   accWr,
	input  wire mmbd_pkg::mmbd_mode_t   accMode,
	input  wire logic [15:0]            accAddr,
	input  wire logic [7:0]             accWdata,
	input  wire logic                   bankWr,
	input  wire logic [2:0]             bankWdata,
	input  wire logic                   prgWr,
	input  wire logic [15:0]            prgAddr,
	input  wire logic [7:0]             prgData,
	output logic      [7:0]             rdata_q,
	output logic                        ack_q,
	output mmbd_pkg::mmbd_region_t      region_q,
	output logic      [15:0]            physAddr_q,
	output logic                        vectorHit_q,
	output logic                        nonvolatileSettingStore_q,
	output logic                        gprHit_q,
	output logic      [2:0]             directBankPointer_q
);
	// ----------------------------------------------------------------
	// Sizes
	// ----------------------------------------------------------------
	localparam int RAM_DEPTH = int'(RAM_END) - int'(RAM_START) + 1; // RAM bytes
	localparam int RAM_AW    = $clog2(RAM_DEPTH);                   // RAM index width
	localparam int FL_DEPTH  = 65536 - int'(FLASH_START);           // Flash bytes
	localparam int FL_AW     = $clog2(FL_DEPTH);                    // Flash index width

	// ----------------------------------------------------------------
	// State
	// ----------------------------------------------------------------
	typedef struct packed {
		logic [BANK_W-1:0]         bank;     // Direct bank pointer
		logic [IO_SIZE-1:0][7:0]   io;       // Peripheral register bytes
		logic                      s1Valid;  // Access in first stage
		mmbd_region_t              s1Region; // Region of first stage
		logic [15:0]               s1Phys;   // Physical address of first stage
		logic                      s1Vec;    // Vector table hit
		logic                      s1Store;  // Setting store hit
		logic                      s1Gpr;    // Register area hit
		logic [7:0]                s1Io;     // Peripheral read value
		logic [7:0]                rdata;    // Answer data
		logic                      ack;      // Answer strobe
		mmbd_region_t              region;   // Answer region
		logic [15:0]               phys;     // Answer physical address
		logic                      vec;      // Answer vector flag
		logic                      store;    // Answer setting store flag
		logic                      gpr;      // Answer register area flag
	} mmbd_state_t;

	// Reset image with each register at its own reset value
	function automatic mmbd_state_t resetState();
		mmbd_state_t s;
		logic [8:0]  info;
		s          = '0;
		s.bank     = BANK_RESET; // [RQ12]
		s.s1Region = RG_NONE;
		s.region   = RG_NONE;
		for (int i = 0; i < IO_SIZE; i++)
		begin
			info    = ioInfo(7'(i));
			s.io[i] = info[7:0];
		end
		return s;
	endfunction

	localparam mmbd_state_t RESET_STATE = resetState(); // Constant reset image

	mmbd_state_t       q;         // Registered state
	mmbd_state_t       d;         // Next state
	logic [15:0]       phys;      // Translated address of the request
	mmbd_region_t      region;    // Region of the request
	logic              vecHit;    // Request hits vector table
	logic              storeHit;  // Request hits setting store
	logic              gprHit;    // Request hits register area
	logic              ramWr;     // RAM write enable
	logic [RAM_AW-1:0] ramIdx;    // RAM index
	logic [7:0]        ramRd;     // RAM read data
	logic              flWr;      // Flash programming enable
	logic [FL_AW-1:0]  flWrIdx;   // Flash programming index
	logic [FL_AW-1:0]  flRdIdx;   // Flash read index
	logic [7:0]        flRd;      // Flash read data
	logic [8:0]        ioSel;     // Implemented flag and value of offset

	// ----------------------------------------------------------------
	// Decode of the current request
	// ----------------------------------------------------------------
	mmbd_translate #(
		.RAM_START   (RAM_START),
		.RAM_END     (RAM_END),
		.FLASH_START (FLASH_START)
	) u_translate (
		.accMode                 (accMode),
		.accAddr                 (accAddr),
		.directBankPointer       (q.bank),
		.physAddr                (phys),
		.region                  (region),
		.vectorHit               (vecHit),
		.nonvolatileSettingStore (storeHit),
		.gprHit                  (gprHit)
	);

	// ----------------------------------------------------------------
	// Memories
	// ----------------------------------------------------------------
	// RAM is written only inside its own range
	assign ramIdx = RAM_AW'(phys - RAM_START);
	assign ramWr  = accReq && accWr && (region == RG_RAM); // [RQ14]

	mmbd_mem #(
		.AW    (RAM_AW),
		.DEPTH (RAM_DEPTH)
	) u_ram (
		.clk    (clk),
		.rst    (rst),
		.wrEn   (ramWr),
		.wrAddr (ramIdx),
		.wrData (accWdata),
		.rdAddr (ramIdx),
		.rdData (ramRd)
	);

	// Flash takes data only from the programming port, never the core
	assign flWr    = prgWr && (prgAddr >= FLASH_START); // [RQ14]
	assign flWrIdx = FL_AW'(prgAddr - FLASH_START);
	assign flRdIdx = FL_AW'(phys - FLASH_START);

	mmbd_mem #(
		.AW    (FL_AW),
		.DEPTH (FL_DEPTH)
	) u_flash (
		.clk    (clk),
		.rst    (rst),
		.wrEn   (flWr),
		.wrAddr (flWrIdx),
		.wrData (prgData),
		.rdAddr (flRdIdx),
		.rdData (flRd)
	);

	// ----------------------------------------------------------------
	// Next state
	// ----------------------------------------------------------------
	always_comb
	begin
		d     = q;
		ioSel = ioInfo(phys[6:0]);
		// Bank pointer load, takes effect from the next request
		if (bankWr)
			d.bank = bankWdata; // [RQ13]
		// Peripheral write to implemented offsets only
		if (accReq && accWr && region == RG_IO && ioSel[8])
			d.io[phys[6:0]] = accWdata; // [RQ2] [RQ14]
		// First stage captures the decode
		d.s1Valid  = accReq;
		d.s1Region = region; // [RQ1]
		d.s1Phys   = phys;
		d.s1Vec    = vecHit;
		d.s1Store  = storeHit;
		d.s1Gpr    = gprHit;
		d.s1Io     = ioSel[8] ? q.io[phys[6:0]] : RST_ZERO;
		// Second stage forms the answer
		d.ack    = q.s1Valid;
		d.region = q.s1Region;
		d.phys   = q.s1Phys;
		d.vec    = q.s1Vec;
		d.store  = q.s1Store;
		d.gpr    = q.s1Gpr;
		case (q.s1Region)
			RG_IO:    d.rdata = q.s1Io;
			RG_RAM:   d.rdata = ramRd;
			RG_FLASH: d.rdata = flRd; // [RQ8] [RQ10]
			default:  d.rdata = RST_ZERO; // [RQ14]
		endcase
	end

	// ----------------------------------------------------------------
	// State register
	// ----------------------------------------------------------------
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
			q <= RESET_STATE;
		else
			q <= d;
	end

	// ----------------------------------------------------------------
	// Outputs
	// ----------------------------------------------------------------
	assign rdata_q                   = q.rdata;
	assign ack_q                     = q.ack;
	assign region_q                  = q.region;
	assign physAddr_q                = q.phys;
	assign vectorHit_q               = q.vec;
	assign nonvolatileSettingStore_q = q.store;
	assign gprHit_q                  = q.gpr;
	assign directBankPointer_q       = q.bank;

	// ----------------------------------------------------------------
	// Assertions
	// ----------------------------------------------------------------
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);

	// Direct and register-area operands and bank of a request
	property pDirLow;
		logic [7:0] op;
		(accReq && accMode == MODE_DIRECT && !accAddr[7], op = accAddr[7:0])
			|-> ##2 physAddr_q == {8'h00, op} && region_q == RG_IO;
	endproperty

	property pBankZero;
		logic [7:0] op;
		(accReq && accMode == MODE_DIRECT && q.bank == BANK_RESET
			&& accAddr[7:0] >= DIRECT_RAM_LOW[7:0], op = accAddr[7:0])
			|-> ##2 physAddr_q == {8'h00, op} && region_q == RG_RAM;
	endproperty

	property pBankWin;
		logic [7:0] op;
		logic [2:0] bk;
		(accReq && accMode == MODE_DIRECT && q.bank != BANK_RESET && accAddr[7],
			op = accAddr[7:0], bk = q.bank)
			|-> ##2 physAddr_q[15:BANK_WIN_LSB] == {6'h00, bk} + 9'h001
			&& physAddr_q[BANK_WIN_LSB-1:0] == op[6:0];
	endproperty

	property pGprMap;
		logic [7:0] op;
		(accReq && accMode == MODE_GPR, op = accAddr[7:0])
			|-> ##2 physAddr_q == GPR_FIRST + {8'h00, op} && gprHit_q;
	endproperty

	a_ack_latency: assert property (accReq |-> ##2 ack_q) // [RQ1]
		else $error("answer strobe not two cycles after request");
	a_ack_spurious: assert property (!accReq |-> ##2 !ack_q) // [RQ1]
		else $error("answer strobe without a request");
	a_io_plain: assert property (accReq && accMode == MODE_PLAIN && accAddr <= IO_LAST // [RQ2]
		|-> ##2 region_q == RG_IO)
		else $error("low addresses did not select peripherals");
	a_xio_plain: assert property (accReq && accMode == MODE_PLAIN // [RQ3]
		&& accAddr >= XIO_FIRST && accAddr <= XIO_LAST |-> ##2 region_q == RG_XIO)
		else $error("extended peripheral area not selected");
	a_dir_low: assert property (pDirLow) // [RQ11]
		else $error("low direct operand moved by bank");
	a_bank_zero: assert property (pBankZero) // [RQ12]
		else $error("bank zero did not map one to one");
	a_bank_window: assert property (pBankWin) // [RQ13]
		else $error("banked window address wrong");
	a_ram_limit: assert property (ack_q && region_q == RG_RAM // [RQ5]
		|-> physAddr_q >= RAM_START && physAddr_q <= RAM_END)
		else $error("RAM selected outside its range");
	a_bank_beyond: assert property (accReq && accMode == MODE_DIRECT // [RQ6]
		&& directMap(accAddr[7:0], q.bank) > RAM_END |-> ##2 region_q == RG_NONE)
		else $error("banked access beyond RAM not refused");
	a_gpr_map: assert property (pGprMap) // [RQ7]
		else $error("register area address wrong");
	a_vector_hit: assert property (accReq && accMode == MODE_PLAIN && accAddr >= VEC_FIRST // [RQ8]
		|-> ##2 vectorHit_q && region_q == RG_FLASH && !nonvolatileSettingStore_q)
		else $error("vector table not flagged");
	a_store_hit: assert property (ack_q && nonvolatileSettingStore_q // [RQ10]
		|-> physAddr_q >= NVSTORE_FIRST && physAddr_q <= NVSTORE_LAST && !vectorHit_q)
		else $error("setting store flagged outside its range");
	a_unmapped_zero: assert property (ack_q && region_q inside {RG_NONE, RG_XIO} // [RQ14]
		|-> rdata_q == RST_ZERO)
		else $error("unmapped read not zero");
	a_flash_top: assert property (ack_q && region_q == RG_FLASH // [RQ15]
		|-> physAddr_q >= FLASH_START)
		else $error("flash selected below its start");
	a_bank_hold: assert property (!bankWr |=> $stable(directBankPointer_q)) // [RQ12]
		else $error("bank pointer changed without a load");
	a_ram_reach: assert property (accReq && accMode == MODE_DIRECT // [RQ4]
		&& accAddr[7:0] >= DIRECT_RAM_LOW[7:0] && q.bank == BANK_RESET
		|-> ##2 physAddr_q <= DIRECT_RAM_HIGH)
		else $error("unbanked direct access left its area");

	c_banked_read: cover property (accReq && !accWr && accMode == MODE_DIRECT
		&& q.bank != BANK_RESET ##2 ack_q && region_q == RG_RAM);
	c_vector_fetch: cover property (accReq && accMode == MODE_VECTOR_CALL ##2 vectorHit_q);
	c_io_write: cover property (accReq && accWr && region == RG_IO && ioSel[8]);
	c_back_to_back: cover property (accReq [*3] ##0 ack_q ##1 ack_q [*2]);
endmodule

// file: mmbd_core_model.sv
// CPU core model that drives the decoder's access, bank and programming ports
`timescale 1ns/1ps
module mmbd_core_model
	import mmbd_pkg::*;
(
	input  wire logic                   clk,
	output mmbd_pkg::mmbd_mode_t        accMode,
	output logic                        accReq,
	output logic                        accWr,
	output logic [15:0]                 accAddr,
	output logic [7:0]                  accWdata,
	output logic                        bankWr,
	output logic [2:0]                  bankWdata,
	output logic                        prgWr,
	output logic [15:0]                 prgAddr,
	output logic [7:0]                  prgData,
	input  wire logic [7:0]             rdata_q,
	input  wire logic                   ack_q,
	input  wire mmbd_pkg::mmbd_region_t region_q,
	input  wire logic [15:0]            physAddr_q,
	input  wire logic [2:0]             flags
);
	import mmbd_pkg::*;
	logic         ackSeen; // Answer arrived in time
	logic [7:0]   lastRd;  // Captured read data
	logic [15:0]  lastRg;  // Captured region code
	logic [15:0]  lastPa;  // Captured physical address
	logic [2:0]   lastFl;  // Captured vector, store, register flags
	// ----------------------------------------------------------------
	// Idle levels at time zero
	// ----------------------------------------------------------------
	initial
	begin
		{accReq, accWr, bankWr, prgWr} = 4'h0;
		accMode = MODE_PLAIN;
		{accAddr, accWdata, bankWdata, prgAddr, prgData} = 51'h0;
	end
	// One byte access; address and write data lines show inverted values afterwards
	task automatic acc(input logic w, input mmbd_mode_t m, input logic [15:0] a,
		input logic [7:0] d);
		@(posedge clk) #1;
		accReq = 1'b1;
		accWr = w;
		accMode = m;
		accAddr = a;
		accWdata = d;
		@(posedge clk) #1;
		accReq = 1'b0;
		accAddr = ~a;
		accWdata = ~d;
		ackSeen = 1'b0;
		for (int k = 0; k < 4 && !ackSeen; k++)
		begin
			if (ack_q === 1'b1)
			begin
				ackSeen = 1'b1;
				{lastRd, lastPa, lastFl} = {rdata_q, physAddr_q, flags};
				lastRg = 16'(region_q);
			end
			else
				@(posedge clk) #1;
		end
	endtask
	// Load the bank pointer with a one-cycle pulse
	task automatic bank(input logic [2:0] b);
		@(posedge clk) #1;
		bankWr = 1'b1;
		bankWdata = b;
		@(posedge clk) #1;
		bankWr = 1'b0;
		bankWdata = ~b;
	endtask
	// Store one flash byte; vectors are routine addresses held as data
	task automatic prg(input logic [15:0] a, input logic [7:0] d);
		@(posedge clk) #1;
		prgWr = 1'b1;
		prgAddr = a;
		prgData = d;
		@(posedge clk) #1;
		prgWr = 1'b0;
		prgAddr = ~a;
		prgData = ~d;
	endtask
endmodule

// file: memory_map_bank_decoder_tb_top.sv
// Self-checking testbench of the memory map bank decoder
`timescale 1ns/1ps
module memory_map_bank_decoder_tb_top;
	import mmbd_pkg::*;
	logic clk, rst, accReq, accWr, bankWr, prgWr, ack, vh, nv, gh;
	mmbd_mode_t   accMode;
	mmbd_region_t region;
	logic [15:0]  accAddr, prgAddr, physAddr;
	logic [7:0]   accWdata, prgData, rdata;
	logic [2:0]   bankWdata, dbp;
	int           n_fail = 0;
	int           checked = 0;
	// ----------------------------------------------------------------
	// Design, core model and clock
	// ----------------------------------------------------------------
	memory_map_bank_decoder uut (.clk(clk), .rst(rst), .accReq(accReq), .accWr(accWr),
		.accMode(accMode), .accAddr(accAddr), .accWdata(accWdata), .bankWr(bankWr),
		.bankWdata(bankWdata), .prgWr(prgWr), .prgAddr(prgAddr), .prgData(prgData),
		.rdata_q(rdata), .ack_q(ack), .region_q(region), .physAddr_q(physAddr),
		.vectorHit_q(vh), .nonvolatileSettingStore_q(nv), .gprHit_q(gh),
		.directBankPointer_q(dbp));
	mmbd_core_model core (.clk(clk), .accMode(accMode), .accReq(accReq), .accWr(accWr),
		.accAddr(accAddr), .accWdata(accWdata), .bankWr(bankWr), .bankWdata(bankWdata),
		.prgWr(prgWr), .prgAddr(prgAddr), .prgData(prgData), .rdata_q(rdata),
		.ack_q(ack), .region_q(region), .physAddr_q(physAddr), .flags({vh, nv, gh}));
	initial
	begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end
	task automatic report_and_stop;
		$display("checked %0d mismatches %0d", checked, n_fail);
		if (n_fail == 0 && checked > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
		checked++;
		if (g !== e)
		begin
			n_fail++;
			$display("[ERR] %s expected %h seen %h", nm, e, g);
		end
	endtask
	// Access with a bounded wait; a missing answer ends the run
	task automatic ac(input logic w, input mmbd_mode_t m, input logic [15:0] a,
		input logic [7:0] d);
		core.acc(w, m, a, d);
		chk("ack seen", 16'h0001, 16'(core.ackSeen));
		if (core.ackSeen !== 1'b1)
			report_and_stop();
	endtask
	// ----------------------------------------------------------------
	// Scenarios
	// ----------------------------------------------------------------
	task automatic t_regs;
		logic [7:0] ofs [5] = '{8'h00, 8'h05, 8'h07, 8'h0d, 8'h2d};
		logic [7:0] rv  [5] = '{8'h00, 8'hff, 8'h1b, 8'h03, 8'h00};
		chk("pointer", 16'h0000, 16'(dbp));
		for (int i = 0; i < 5; i++)
		begin
			ac(1'b0, MODE_PLAIN, {8'h00, ofs[i]}, 8'h00);
			chk("reset value", 16'(rv[i]), 16'(core.lastRd));
			chk("region", 16'h0002, core.lastRg);
		end
		ac(1'b1, MODE_PLAIN, 16'h002c, 8'ha5);
		ac(1'b0, MODE_DIRECT, 16'h002c, 8'h00);
		chk("direct io read", 16'h00a5, 16'(core.lastRd));
		ac(1'b1, MODE_PLAIN, 16'h0004, 8'h99);
		ac(1'b0, MODE_PLAIN, 16'h0004, 8'h00);
		chk("disabled io", 16'h0000, 16'(core.lastRd));
		$display("test regs done");
	endtask
	// Reset in mid-run clears the pointer and the peripheral register at 0x2c
	task automatic t_rst;
		core.bank(3'h5);
		@(posedge clk) #1 rst = 1'b1;
		@(posedge clk) #1 rst = 1'b0;
		chk("pointer after reset", 16'h0000, 16'(dbp));
		ac(1'b0, MODE_PLAIN, 16'h002c, 8'h00);
		chk("reg after reset", 16'h0000, 16'(core.lastRd));
		$display("test reset done");
	endtask
	task automatic t_bank;
		logic [15:0] pa;
		for (int b = 0; b < 8; b++)
		begin
			core.bank(3'(b));
			chk("pointer", 16'(b), 16'(dbp));
			pa = (b == 0) ? 16'h0085 : 16'(16'h0085 + b * 128);
			ac(1'b1, MODE_DIRECT, 16'h0085, 8'(8'h40 + b));
			chk("banked phys", pa, core.lastPa);
			chk("banked region", 16'h0008, core.lastRg);
			ac(1'b0, MODE_DIRECT, 16'h0010, 8'h00);
			chk("low operand", 16'h0010, core.lastPa);
			ac(1'b0, MODE_PLAIN, pa, 8'h00);
			chk("banked data", 16'(8'h40 + b), 16'(core.lastRd));
		end
		core.bank(3'h0);
		$display("test bank done");
	endtask
	task automatic t_gpr;
		ac(1'b1, MODE_GPR, 16'h0022, 8'h3c);
		chk("gpr phys", 16'h0122, core.lastPa);
		ac(1'b0, MODE_PLAIN, 16'h0122, 8'h00);
		chk("gpr as ram", 16'h003c, 16'(core.lastRd));
		chk("gpr flag", 16'h0001, 16'(core.lastFl));
		$display("test gpr done");
	endtask
	task automatic t_holes;
		logic [15:0] ad [5] = '{16'h0f80, 16'h0fff, 16'h0480, 16'h2000, 16'h8000};
		logic [15:0] rg [5] = '{16'h0004, 16'h0004, 16'h0001, 16'h0001, 16'h0010};
		core.prg(16'h8000, 8'h77);
		for (int i = 0; i < 5; i++)
		begin
			ac(1'b1, MODE_PLAIN, ad[i], 8'h5a);
			ac(1'b0, MODE_PLAIN, ad[i], 8'h00);
			chk("hole region", rg[i], core.lastRg);
			chk("hole data", (i == 4) ? 16'h0077 : 16'h0000, 16'(core.lastRd));
		end
		$display("test holes done");
	endtask
	task automatic t_vec;
		core.prg(16'hffc0, 8'h23);
		core.prg(16'hffc1, 8'h81);
		ac(1'b0, MODE_VECTOR_CALL, 16'h0001, 8'h00);
		chk("vector phys", 16'hffc1, core.lastPa);
		chk("vector data", 16'h0081, 16'(core.lastRd));
		chk("vector flag", 16'h0004, 16'(core.lastFl));
		ac(1'b0, MODE_PLAIN, 16'hffbb, 8'h00);
		chk("store flag", 16'h0002, 16'(core.lastFl));
		ac(1'b0, MODE_PLAIN, 16'hffba, 8'h00);
		chk("below store", 16'h0000, 16'(core.lastFl));
		$display("test vector done");
	endtask
	initial
	begin
		rst = 1'b1;
		repeat (5) @(posedge clk);
		#1 rst = 1'b0;
		t_regs();
		t_bank();
		t_gpr();
		t_holes();
		t_vec();
		t_rst();
		report_and_stop();
	end
endmodule
